// ### verification/register_indirect_jump_unit_test.sv
// register_indirect_jump_unit_test: directed bench of the register indirect jump unit
module register_indirect_jump_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_n_i = 1'b0, newer_release_i = 1'b0, release2_i = 1'b0;
    logic compressed_isa_i = 1'b0, instr_valid_i = 1'b0;
    logic [31:0] instr_i = 32'h0, index_reg_value_i = 32'h0, source_reg_value_i = 32'h0;
    logic pc_load_o, instruction_set_mode_bit_o, squash_next_o, barrier_o, addr_error_o;
    logic reserved_instr_o, branch_if_zero_compact_o, legacy_cop2_doubleword_load_o;
    logic in_delay_slot_o;
    logic [31:0] pc_target_o, addr_error_addr_o;
    int miscompares = 0, samples_checked = 0, cycles = 0;

    rijump_unit #(.XLEN(32)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .newer_release_i(newer_release_i), .release2_i(release2_i),
        .compressed_isa_i(compressed_isa_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .index_reg_value_i(index_reg_value_i), .source_reg_value_i(source_reg_value_i),
        .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .squash_next_o(squash_next_o),
        .instruction_set_mode_bit_o(instruction_set_mode_bit_o), .barrier_o(barrier_o),
        .addr_error_o(addr_error_o), .addr_error_addr_o(addr_error_addr_o),
        .reserved_instr_o(reserved_instr_o), .in_delay_slot_o(in_delay_slot_o),
        .branch_if_zero_compact_o(branch_if_zero_compact_o),
        .legacy_cop2_doubleword_load_o(legacy_cop2_doubleword_load_o));

    // ------------------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ------------------------------------------------------------------------
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // the whole run needs well under a hundred cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one valid word; returns where the registered answer has settled
    task automatic issue(input logic [31:0] ins, input logic [31:0] idx, input logic [31:0] src);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= ins;
        index_reg_value_i <= idx;
        source_reg_value_i <= src;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        @(negedge clk_i);
    endtask : issue
    task automatic expect_jump(input logic [31:0] tgt, input logic mode, input logic err);
        check(pc_load_o, 1'b1);
        check(pc_target_o, tgt);
        check(instruction_set_mode_bit_o, mode);
        @(negedge clk_i);
        check(addr_error_o, err);
        if (err) begin
            check(addr_error_addr_o, tgt);
        end
    endtask : expect_jump

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_compact();
        newer_release_i <= 1'b1;
        issue({6'h36, 10'h003, 16'hfffc}, 32'h0000_1000, 32'h0);
        check(squash_next_o, 1'b1);
        expect_jump(32'h0000_0ffc, 1'b0, 1'b0);
        issue({6'h36, 10'h003, 16'h0001}, 32'h0000_1001, 32'h0);
        expect_jump(32'h0000_1002, 1'b0, 1'b1);
        @(posedge clk_i);
        compressed_isa_i <= 1'b1;
        issue({6'h36, 10'h003, 16'h0001}, 32'h0000_2000, 32'h0);
        expect_jump(32'h0000_2000, 1'b1, 1'b0);
        issue({6'h36, 10'h003, 16'h0002}, 32'h0000_2000, 32'h0);
        expect_jump(32'h0000_2002, 1'b0, 1'b1);
    endtask : t_compact
    task automatic t_side_decodes();
        @(posedge clk_i);
        compressed_isa_i <= 1'b0;
        issue({6'h36, 10'h143, 16'h0010}, 32'h0, 32'h0);
        check(branch_if_zero_compact_o, 1'b1);
        check(pc_load_o, 1'b0);
        issue({6'h00, 5'h04, 15'h0000, 6'h08}, 32'h0, 32'h0000_4000);
        check(reserved_instr_o, 1'b1);
        @(posedge clk_i);
        newer_release_i <= 1'b0;
        issue({6'h36, 10'h003, 16'h0010}, 32'h0, 32'h0);
        check(legacy_cop2_doubleword_load_o, 1'b1);
        check(pc_load_o, 1'b0);
    endtask : t_side_decodes
    task automatic t_reg_jumps();
        @(posedge clk_i);
        release2_i <= 1'b1;
        issue({6'h00, 5'h04, 10'h000, 5'h10, 6'h08}, 32'h0, 32'h0000_4000);
        check(pc_load_o, 1'b0);
        repeat (2) @(posedge clk_i);
        issue(32'h0, 32'h0, 32'hdead_0000);
        check(in_delay_slot_o, 1'b1);
        check(barrier_o, 1'b1);
        check(squash_next_o, 1'b0);
        expect_jump(32'h0000_4000, 1'b0, 1'b0);
        @(posedge clk_i);
        newer_release_i <= 1'b1;
        compressed_isa_i <= 1'b1;
        issue({6'h00, 5'h04, 15'h0000, 6'h09}, 32'h0, 32'h0000_5003);
        issue(32'h0, 32'h0, 32'h0);
        check(barrier_o, 1'b0);
        expect_jump(32'h0000_5002, 1'b1, 1'b0);
        // hint bit 10 set: the newer release honours the barrier as well
        issue({6'h00, 5'h04, 15'h0010, 6'h09}, 32'h0, 32'h0000_6002);
        issue(32'h0, 32'h0, 32'h0);
        check(barrier_o, 1'b1);
        expect_jump(32'h0000_6002, 1'b0, 1'b1);
    endtask : t_reg_jumps
    task automatic t_slot_transfer();
        issue({6'h00, 5'h04, 15'h0000, 6'h09}, 32'h0, 32'h0000_7000);
        issue({6'h36, 10'h003, 16'h0000}, 32'h0000_8000, 32'h0);
        check(reserved_instr_o, 1'b1);
        check(pc_load_o, 1'b0);
    endtask : t_slot_transfer

    // reset for ten cycles, then run every scenario
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_compact();
        t_side_decodes();
        t_reg_jumps();
        t_slot_transfer();
        wrap_up();
    end
endmodule : register_indirect_jump_unit_test

// ### verification/rijump_unit_asserts.sv
// rijump_asserts: port-level checker of the register indirect jump unit
module rijump_asserts
    import rijump_pkg::*;
#(
    parameter int XLEN = 32
) (
    // clock, reset and straps
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic newer_release_i,
    input wire logic compressed_isa_i,
    // instruction side
    input wire logic instr_valid_i,
    input wire logic [31:0] instr_i,
    input wire logic [XLEN-1:0] index_reg_value_i,
    // results
    input wire logic pc_load_o,
    input wire logic [XLEN-1:0] pc_target_o,
    input wire logic instruction_set_mode_bit_o,
    input wire logic squash_next_o,
    input wire logic addr_error_o,
    input wire logic [XLEN-1:0] addr_error_addr_o,
    input wire logic reserved_instr_o,
    input wire logic legacy_cop2_doubleword_load_o,
    input wire logic in_delay_slot_o
);
    // ------------------------------------------------------------------------
    // shadow decode, so antecedents skip the slot instruction
    // ------------------------------------------------------------------------
    logic slot_reg;
    wire [5:0] op_w = instr_i[31:26];
    wire [5:0] fn_w = instr_i[5:0];
    wire jr_w = (op_w == OP_REGISTER_FORMAT) && (instr_i[20:11] == LEGACY_ZERO_FIELD) &&
        (fn_w == (newer_release_i ? FUNCT_JUMP_REG_LINK : FUNCT_JUMP_REG_LEGACY));
    wire jic_w = newer_release_i && (op_w == OP_INDEXED_JUMP) && (instr_i[25:21] == FIELD_ZERO);
    wire idle_w = instr_valid_i && !slot_reg;
    wire [XLEN-1:0] sum_w = index_reg_value_i + {{(XLEN-16){instr_i[15]}}, instr_i[15:0]};

    // a register jump makes the next valid word its slot
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            slot_reg <= 1'b0;
        end else if (instr_valid_i) begin
            slot_reg <= !slot_reg && jr_w;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_compact_target: assert property (idle_w && jic_w |=> pc_load_o && squash_next_o &&
        pc_target_o == {$past(sum_w[XLEN-1:1]), $past(sum_w[0]) & !compressed_isa_i})
        else $error("compact jump target wrong");
    a_compact_mode: assert property (idle_w && jic_w && compressed_isa_i |=>
        instruction_set_mode_bit_o == $past(sum_w[0])) else $error("compact jump mode wrong");
    a_squash_with_load: assert property (squash_next_o |-> pc_load_o)
        else $error("squash without load");
    a_jump_waits_slot: assert property (idle_w && jr_w |=> !pc_load_o)
        else $error("register jump loaded before slot");
    a_slot_marked: assert property (instr_valid_i && slot_reg |=> in_delay_slot_o)
        else $error("slot not marked");
    a_old_code_reserved: assert property (idle_w && newer_release_i && op_w == 6'h00 &&
        fn_w == 6'h08 |=> reserved_instr_o) else $error("old register jump accepted");
    a_legacy_load: assert property (idle_w && !newer_release_i && op_w == 6'h36 |=>
        legacy_cop2_doubleword_load_o && !pc_load_o) else $error("legacy load not decoded");
    a_error_plain: assert property (pc_load_o && !compressed_isa_i |=>
        addr_error_o == ($past(pc_target_o[1:0]) != 2'b00)) else $error("plain error wrong");
    a_error_mixed: assert property (pc_load_o && compressed_isa_i |=>
        addr_error_o == (!$past(instruction_set_mode_bit_o) && $past(pc_target_o[1])))
        else $error("mixed error wrong");
    a_error_after_load: assert property (addr_error_o |-> $past(pc_load_o) &&
        addr_error_addr_o == $past(pc_target_o)) else $error("error address wrong");
endmodule : rijump_asserts

bind rijump_unit rijump_asserts #(.XLEN(XLEN)) chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .newer_release_i(newer_release_i), .compressed_isa_i(compressed_isa_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .index_reg_value_i(index_reg_value_i),
    .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .squash_next_o(squash_next_o),
    .instruction_set_mode_bit_o(instruction_set_mode_bit_o), .addr_error_o(addr_error_o),
    .addr_error_addr_o(addr_error_addr_o), .reserved_instr_o(reserved_instr_o),
    .legacy_cop2_doubleword_load_o(legacy_cop2_doubleword_load_o),
    .in_delay_slot_o(in_delay_slot_o));

// ### verilog/rijump_pkg.sv
// rijump_pkg: encodings, field positions and reset values of the register indirect jump unit
// ----------------------------------------------------------------------------
// Function
// - indexed major opcode, zero source field, is compact jump
// - target is index register plus sign-extended offset
// - compressed set: mode from bit 0, clear bit 0
// - compact jump always taken, next instruction squashed
// - newer release: no legacy load on indexed opcode
// - compact jump always present in newer release
// - legacy register jump: function 001000, zero field
// - newer release uses function 001001, legacy reserved
// - register jump executes one delay-slot instruction first
// - no compressed set: low two bits misaligned error
// - compressed set: bit 0 zero, bit 1 one errors
// - newer release: control transfer in slot reserved
// - hint zero default; hint bit 10 requests barrier
// ----------------------------------------------------------------------------
package rijump_pkg;

    // ------------------------------------------------------------------------
    // instruction fields
    // ------------------------------------------------------------------------
    localparam int OPCODE_MSB = 31;
    localparam int OPCODE_LSB = 26;
    localparam int SRC_MSB = 25;
    localparam int SRC_LSB = 21;
    localparam int IDX_MSB = 20;
    localparam int IDX_LSB = 16;
    localparam int DST_MSB = 15;
    localparam int DST_LSB = 11;
    localparam int HINT_BARRIER_BIT = 10;
    localparam int FUNCT_MSB = 5;
    localparam int FUNCT_LSB = 0;

    // ------------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------------
    localparam logic [5:0] OP_REGISTER_FORMAT = 6'h00;
    localparam logic [5:0] OP_REGIMM = 6'h01;
    localparam logic [5:0] OP_JUMP = 6'h02;
    localparam logic [5:0] OP_JUMP_LINK = 6'h03;
    localparam logic [3:0] OP_BRANCH_GROUP = 4'h1; // opcodes 0001xx
    localparam logic [5:0] OP_INDEXED_JUMP = 6'h36;
    localparam logic [5:0] OP_INDEXED_JUMP_LINK = 6'h3e;
    localparam logic [5:0] FUNCT_JUMP_REG_LEGACY = 6'h08;
    localparam logic [5:0] FUNCT_JUMP_REG_LINK = 6'h09;
    localparam logic [4:0] FIELD_ZERO = 5'h00;
    localparam logic [9:0] LEGACY_ZERO_FIELD = 10'h000;

    // ------------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------------
    localparam logic [31:0] TARGET_RESET = 32'h0000_0000;
    localparam logic ISA_MODE_RESET = 1'b0;

    // ------------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        RIJ_IDLE = 2'b01,
        RIJ_SLOT = 2'b10
    } rijump_state_type;

endpackage : rijump_pkg

// ### verilog/rijump_unit.sv
// rijump_unit: decode and execute of the compact indexed jump and the register jump
module rijump_unit
    import rijump_pkg::*;
#(
    parameter int XLEN = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // configuration straps
    input wire logic newer_release_i,
    input wire logic release2_i,
    input wire logic compressed_isa_i,
    // instruction from decode stage with register operands
    input wire logic instr_valid_i,
    input wire logic [31:0] instr_i,
    input wire logic [XLEN-1:0] index_reg_value_i,
    input wire logic [XLEN-1:0] source_reg_value_i,
    // program counter update
    output logic pc_load_o,
    output logic [XLEN-1:0] pc_target_o,
    output logic instruction_set_mode_bit_o,
    output logic squash_next_o,
    output logic barrier_o,
    // exceptions and side decodes
    output logic addr_error_o,
    output logic [XLEN-1:0] addr_error_addr_o,
    output logic reserved_instr_o,
    output logic branch_if_zero_compact_o,
    output logic legacy_cop2_doubleword_load_o,
    output logic in_delay_slot_o
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------

    // any branch or jump, used to police the delay slot
    function automatic logic is_cti(input logic [31:0] ins);
        logic [5:0] op;
        logic [5:0] fn;
        op = ins[OPCODE_MSB:OPCODE_LSB];
        fn = ins[FUNCT_MSB:FUNCT_LSB];
        is_cti = (op == OP_REGIMM) || (op == OP_JUMP) || (op == OP_JUMP_LINK)
            || (op[5:2] == OP_BRANCH_GROUP) || (op == OP_INDEXED_JUMP)
            || (op == OP_INDEXED_JUMP_LINK)
            || ((op == OP_REGISTER_FORMAT)
                && ((fn == FUNCT_JUMP_REG_LEGACY) || (fn == FUNCT_JUMP_REG_LINK)));
    endfunction : is_cti

    // fetch alignment check of a raw target, before bit 0 is cleared
    function automatic logic misaligned(input logic [1:0] low, input logic comp);
        misaligned = comp ? (!low[0] && low[1]) : (low != 2'b00);
    endfunction : misaligned

    // ------------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------------
    wire logic [5:0] opcode = instr_i[OPCODE_MSB:OPCODE_LSB];
    wire logic [5:0] funct = instr_i[FUNCT_MSB:FUNCT_LSB];
    wire logic [4:0] src_field = instr_i[SRC_MSB:SRC_LSB];
    wire logic [4:0] idx_field = instr_i[IDX_MSB:IDX_LSB];
    wire logic [4:0] dst_field = instr_i[DST_MSB:DST_LSB];
    wire logic is_indexed_op = (opcode == OP_INDEXED_JUMP);
    wire logic is_reg_fmt = (opcode == OP_REGISTER_FORMAT);

    // indexed opcode is the compact pair only in the newer release
    wire logic dec_compact = is_indexed_op && newer_release_i
        && (src_field == FIELD_ZERO);
    wire logic dec_branch_if_zero_compact = is_indexed_op && newer_release_i
        && (src_field != FIELD_ZERO);
    wire logic dec_legacy_load = is_indexed_op && !newer_release_i;

    // register jump encodings differ between releases
    wire logic dec_jr_legacy = is_reg_fmt && !newer_release_i
        && (funct == FUNCT_JUMP_REG_LEGACY)
        && (instr_i[IDX_MSB:DST_LSB] == LEGACY_ZERO_FIELD);
    wire logic dec_jr_newer = is_reg_fmt && newer_release_i
        && (funct == FUNCT_JUMP_REG_LINK) && (idx_field == FIELD_ZERO)
        && (dst_field == FIELD_ZERO);
    wire logic dec_jr_removed = is_reg_fmt && newer_release_i
        && (funct == FUNCT_JUMP_REG_LEGACY);
    wire logic dec_jr = dec_jr_legacy || dec_jr_newer;

    // hint zero is plain handling; the upper hint bit asks for a barrier
    wire logic dec_barrier = (release2_i || newer_release_i)
        && instr_i[HINT_BARRIER_BIT];

    // ------------------------------------------------------------------------
    // target formation
    // ------------------------------------------------------------------------

    // offset added unshifted so tag bits in the low end can be cancelled
    wire logic [XLEN-1:0] offset_ext = {{(XLEN-16){instr_i[15]}}, instr_i[15:0]};
    wire logic [XLEN-1:0] compact_raw = index_reg_value_i + offset_ext;
    wire logic [XLEN-1:0] compact_pc = compressed_isa_i
        ? {compact_raw[XLEN-1:1], 1'b0} : compact_raw;
    wire logic compact_mode = compressed_isa_i ? compact_raw[0]
        : instruction_set_mode_bit_o;
    wire logic compact_bad = misaligned(compact_raw[1:0], compressed_isa_i);

    wire logic [XLEN-1:0] jr_pc = compressed_isa_i
        ? {source_reg_value_i[XLEN-1:1], 1'b0} : source_reg_value_i;
    wire logic jr_mode = compressed_isa_i ? source_reg_value_i[0]
        : instruction_set_mode_bit_o;
    wire logic jr_bad = misaligned(source_reg_value_i[1:0], compressed_isa_i);

    // ------------------------------------------------------------------------
    // sequencer state and pending jump
    // ------------------------------------------------------------------------
    rijump_state_type state_reg;
    rijump_state_type state_next;
    logic [XLEN-1:0] pend_pc_reg;
    logic pend_mode_reg;
    logic pend_bad_reg;
    logic pend_barrier_reg;
    logic err_pend_reg;

    wire logic idle = (state_reg == RIJ_IDLE);
    wire logic take_compact = idle && instr_valid_i && dec_compact;
    wire logic take_jr = idle && instr_valid_i && dec_jr;
    wire logic slot_arrive = (state_reg == RIJ_SLOT) && instr_valid_i;
    // the legacy release leaves a slot transfer undefined, so it is not policed
    wire logic slot_cti = slot_arrive && newer_release_i && is_cti(instr_i);
    wire logic slot_done = slot_arrive && !slot_cti;

    // next state: a register jump waits for exactly one slot instruction
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RIJ_IDLE: begin
                if (take_jr) begin
                    state_next = RIJ_SLOT;
                end
            end
            RIJ_SLOT: begin
                if (slot_arrive) begin
                    state_next = RIJ_IDLE;
                end
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= RIJ_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // capture the register jump target when it is decoded
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pend_pc_reg <= TARGET_RESET;
            pend_mode_reg <= ISA_MODE_RESET;
            pend_bad_reg <= 1'b0;
            pend_barrier_reg <= 1'b0;
        end else if (take_jr) begin
            pend_pc_reg <= jr_pc;
            pend_mode_reg <= jr_mode;
            pend_bad_reg <= jr_bad;
            pend_barrier_reg <= dec_barrier;
        end
    end

    // ------------------------------------------------------------------------
    // program counter update
    // ------------------------------------------------------------------------
    wire logic load_now = take_compact || slot_done;
    wire logic bad_now = take_compact ? compact_bad : (slot_done && pend_bad_reg);

    // compact jump loads at once; register jump after its slot instruction
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pc_load_o <= 1'b0;
            pc_target_o <= TARGET_RESET;
            instruction_set_mode_bit_o <= ISA_MODE_RESET;
            squash_next_o <= 1'b0;
            barrier_o <= 1'b0;
            err_pend_reg <= 1'b0;
        end else begin
            pc_load_o <= load_now;
            squash_next_o <= take_compact;
            barrier_o <= slot_done && pend_barrier_reg;
            err_pend_reg <= load_now && bad_now;
            if (take_compact) begin
                pc_target_o <= compact_pc;
                instruction_set_mode_bit_o <= compact_mode;
            end else if (slot_done) begin
                pc_target_o <= pend_pc_reg;
                instruction_set_mode_bit_o <= pend_mode_reg;
            end
        end
    end

    // ------------------------------------------------------------------------
    // exceptions and side decodes
    // ------------------------------------------------------------------------

    // the error belongs to the target fetch, one cycle after the update
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            addr_error_o <= 1'b0;
            addr_error_addr_o <= TARGET_RESET;
        end else begin
            addr_error_o <= err_pend_reg;
            if (err_pend_reg) begin
                addr_error_addr_o <= pc_target_o;
            end
        end
    end

    // a slot violation cancels the pending jump; the exception takes over
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reserved_instr_o <= 1'b0;
            branch_if_zero_compact_o <= 1'b0;
            legacy_cop2_doubleword_load_o <= 1'b0;
            in_delay_slot_o <= 1'b0;
        end else begin
            reserved_instr_o <= slot_cti || (idle && instr_valid_i && dec_jr_removed);
            branch_if_zero_compact_o <= idle && instr_valid_i && dec_branch_if_zero_compact;
            legacy_cop2_doubleword_load_o <= idle && instr_valid_i && dec_legacy_load;
            in_delay_slot_o <= slot_arrive;
        end
    end

endmodule : rijump_unit
